// ### design/sfe_flash_dev.sv
`timescale 1ns/1ps
module sfe_flash_dev #(
    parameter int ERASE_CYCLES = sfe_pkg::ERASE_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    sfe_spi_if.device spi,
    input wire logic write_enable_latch,
    input wire logic [2:0] secreg_lock_bits,
    output logic busy,
    output logic latch_clear,
    input wire logic prog_we,
    input wire logic [1:0] prog_sel,
    input wire logic [7:0] prog_addr,
    input wire logic [7:0] prog_data,
    input wire logic [1:0] rd_sel,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data
);

    typedef struct packed {
        logic [5:0] cnt;
        logic [23:0] sh;
        logic [7:0] op;
        sfe_pkg::sfe_lmode_t mode;
        logic [7:0] ptr;
        logic [2:0] bsel;
        logic [7:0] obyte;
    } sfe_lnk_t;

    typedef struct packed {
        logic armed;
        logic [1:0] sel;
        logic [4:0] s1;
        logic [4:0] s2;
    } sfe_arm_t;

    typedef struct packed {
        logic so;
        logic oe;
    } sfe_out_t;

    typedef struct packed {
        logic [2:0] csq;
        logic cs_lvl;
        logic [2:0] armq;
        logic taken;
        logic busy;
        logic [1:0] esel;
        logic [31:0] cnt;
        logic latch_clear;
    } sfe_core_t;

    sfe_lnk_t l;
    sfe_lnk_t next_l;
    sfe_arm_t a;
    sfe_arm_t next_a;
    sfe_out_t o;
    sfe_core_t c;
    sfe_core_t next_c;
    logic [7:0] mem [0:3*sfe_pkg::SECREG_BYTES-1];

    logic busy_s;
    logic latch_s;
    logic [2:0] lock_s;
    logic [7:0] status;
    logic [23:0] ea;
    logic [3:0] code;
    logic erase_ok;
    logic cs_rise;

    assign busy_s = a.s2[0];
    assign latch_s = a.s2[1];
    assign lock_s = a.s2[4:2];
    assign ea = {l.sh[22:0], spi.si};
    assign code = ea[15:12];

    always_comb begin
        status = 8'h00;
        status[sfe_pkg::STAT_BUSY_BIT] = busy_s;
        status[sfe_pkg::STAT_LATCH_BIT] = latch_s;
    end

    // ------------------------------------------------------------
    // link side, cleared whenever chip select is high
    // ------------------------------------------------------------
    always_comb begin
        next_l = l;
        if (l.cnt != sfe_pkg::LINK_CNT_MAX) begin
            next_l.cnt = l.cnt + 6'h01;
        end
        next_l.sh = ea;
        unique case (l.mode)
            sfe_pkg::LM_CMD: begin
                if (l.cnt == sfe_pkg::OP_LAST_CNT) begin
                    next_l.op = ea[7:0];
                    if (busy_s && ea[7:0] != sfe_pkg::OP_STATUS) begin
                        next_l.mode = sfe_pkg::LM_IGNORE;
                    end else if (ea[7:0] == sfe_pkg::OP_STATUS) begin
                        next_l.mode = sfe_pkg::LM_STAT;
                        next_l.obyte = status;
                        next_l.bsel = 3'h7;
                    end else if (ea[7:0] == sfe_pkg::OP_SFDP ||
                                 ea[7:0] == sfe_pkg::OP_ERASE) begin
                        next_l.mode = sfe_pkg::LM_ADDR;
                    end else begin
                        next_l.mode = sfe_pkg::LM_IGNORE;
                    end
                end
            end
            sfe_pkg::LM_ADDR: begin
                if (l.cnt == sfe_pkg::ADDR_LAST_CNT) begin
                    next_l.mode = sfe_pkg::LM_IGNORE;
                    if (l.op == sfe_pkg::OP_SFDP && ea[23:8] == 16'h0000) begin
                        next_l.mode = sfe_pkg::LM_DUMMY;
                        next_l.ptr = ea[7:0];
                    end
                end
            end
            sfe_pkg::LM_DUMMY: begin
                if (l.cnt == sfe_pkg::DUMMY_LAST_CNT) begin
                    next_l.mode = sfe_pkg::LM_SFDP;
                    next_l.obyte = sfe_pkg::sfe_table_byte(l.ptr);
                    next_l.bsel = 3'h7;
                end
            end
            sfe_pkg::LM_SFDP, sfe_pkg::LM_STAT: begin
                next_l.bsel = l.bsel - 3'h1;
                if (l.bsel == 3'h0) begin
                    if (l.mode == sfe_pkg::LM_SFDP) begin
                        next_l.ptr = l.ptr + 8'h01;
                        next_l.obyte = sfe_pkg::sfe_table_byte(next_l.ptr);
                    end else begin
                        next_l.obyte = status;
                    end
                end
            end
            sfe_pkg::LM_IGNORE: begin
            end
            default: begin
                next_l.mode = sfe_pkg::LM_IGNORE;
            end
        endcase
    end

    always_ff @(posedge spi.sclk or posedge spi.cs_n) begin
        if (spi.cs_n) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    // ------------------------------------------------------------
    // erase qualification on the link clock
    // ------------------------------------------------------------
    always_comb begin
        next_a = a;
        next_a.s1 = {secreg_lock_bits, write_enable_latch, c.busy};
        next_a.s2 = a.s1;
        erase_ok = 1'b0;
        if (l.mode == sfe_pkg::LM_ADDR && l.cnt == sfe_pkg::ADDR_LAST_CNT &&
            l.op == sfe_pkg::OP_ERASE) begin
            if (ea[23:16] == 8'h00 && ea[11:8] == 4'h0 && code != 4'h0 &&
                code <= sfe_pkg::SECREG_CODE_MAX) begin
                erase_ok = latch_s && !busy_s &&
                           !lock_s[2'(code[1:0] - 2'h1)];
            end
        end
        next_a.armed = erase_ok;
        if (erase_ok) begin
            next_a.sel = code[1:0];
        end
    end

    always_ff @(posedge spi.sclk or posedge reset) begin
        if (reset) begin
            a <= '0;
        end else begin
            a <= next_a;
        end
    end

    always_ff @(negedge spi.sclk or posedge spi.cs_n) begin
        if (spi.cs_n) begin
            o <= '0;
        end else begin
            o.so <= l.obyte[l.bsel];
            o.oe <= l.mode == sfe_pkg::LM_SFDP || l.mode == sfe_pkg::LM_STAT;
        end
    end

    assign spi.so = o.so;
    assign spi.so_oe = o.oe;

    // ------------------------------------------------------------
    // erase timer on the core clock
    // ------------------------------------------------------------
    assign cs_rise = c.csq[1] && c.csq[2] && !c.cs_lvl;

    always_comb begin
        next_c = c;
        next_c.csq = {c.csq[1:0], spi.cs_n};
        next_c.armq = {c.armq[1:0], a.armed};
        next_c.latch_clear = 1'b0;
        if (c.csq[1] == c.csq[2]) begin
            next_c.cs_lvl = c.csq[2];
        end
        if (!c.armq[1] && !c.armq[2]) begin
            next_c.taken = 1'b0;
        end
        if (c.busy) begin
            if (c.cnt == 32'(ERASE_CYCLES - 1)) begin
                next_c.busy = 1'b0;
                next_c.latch_clear = 1'b1;
            end else begin
                next_c.cnt = c.cnt + 32'h0000_0001;
            end
        end else if (cs_rise && c.armq[1] && c.armq[2] && !c.taken) begin
            next_c.busy = 1'b1;
            next_c.cnt = 32'h0000_0000;
            next_c.esel = a.sel;
            next_c.taken = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            c <= '0;
            c.csq <= 3'h7;
            c.cs_lvl <= 1'b1;
        end else begin
            c <= next_c;
        end
    end

    assign busy = c.busy;
    assign latch_clear = c.latch_clear;

    // ------------------------------------------------------------
    // security register storage
    // ------------------------------------------------------------
    // one register wiped per erase
    always_ff @(posedge core_clk) begin
        if (c.busy && c.cnt < 32'(sfe_pkg::SECREG_BYTES)) begin
            mem[{2'(c.esel - 2'h1), c.cnt[7:0]}] <= sfe_pkg::ERASED_BYTE;
        end else if (prog_we && prog_sel != 2'h0) begin
            mem[{2'(prog_sel - 2'h1), prog_addr}] <= prog_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset || rd_sel == 2'h0) begin
            rd_data <= sfe_pkg::ERASED_BYTE;
        end else begin
            rd_data <= mem[{2'(rd_sel - 2'h1), rd_addr}];
        end
    end

endmodule

// ### design/sfe_flash_host.sv
`timescale 1ns/1ps
module sfe_flash_host (
    input wire logic core_clk,
    input wire logic reset,
    sfe_spi_if.host spi,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire sfe_pkg::sfe_hkind_t cmd_kind,
    input wire logic [23:0] cmd_addr,
    input wire logic [7:0] cmd_len,
    output logic rsp_valid,
    output logic [7:0] rsp_data
);

    typedef struct packed {
        sfe_pkg::sfe_hstate_t state;
        logic sclk;
        logic cs_n;
        logic si;
        logic [39:0] sh;
        logic [11:0] cnt;
        logic [11:0] hdr;
        logic [11:0] total;
        logic [7:0] rx;
        logic [2:0] rxn;
        logic rsp_valid;
        logic [7:0] rsp_data;
        logic [1:0] gap;
    } sfe_host_t;

    sfe_host_t h;
    sfe_host_t next_h;
    logic [7:0] op;
    logic [11:0] hdr;
    logic reads;

    always_comb begin
        op = sfe_pkg::OP_WREN;
        hdr = sfe_pkg::HDR_OP;
        reads = 1'b0;
        unique case (cmd_kind)
            sfe_pkg::HK_WREN: begin
            end
            sfe_pkg::HK_STATUS: begin
                op = sfe_pkg::OP_STATUS;
                reads = 1'b1;
            end
            sfe_pkg::HK_SFDP: begin
                op = sfe_pkg::OP_SFDP;
                hdr = sfe_pkg::HDR_SFDP;
                reads = 1'b1;
            end
            sfe_pkg::HK_ERASE: begin
                op = sfe_pkg::OP_ERASE;
                hdr = sfe_pkg::HDR_ERASE;
            end
        endcase
    end

    always_comb begin
        next_h = h;
        next_h.rsp_valid = 1'b0;
        unique case (h.state)
            sfe_pkg::HS_IDLE: begin
                next_h.cs_n = 1'b1;
                next_h.sclk = 1'b0;
                if (cmd_valid) begin
                    next_h.sh = {op, cmd_addr, 8'h00};
                    next_h.si = op[7];
                    next_h.hdr = hdr;
                    next_h.total = reads ? hdr + {1'b0, cmd_len, 3'b000} : hdr;
                    next_h.cnt = 12'h000;
                    next_h.rxn = 3'h0;
                    next_h.cs_n = 1'b0;
                    next_h.state = sfe_pkg::HS_RUN;
                end
            end
            sfe_pkg::HS_RUN: begin
                if (!h.sclk) begin
                    next_h.sclk = 1'b1;
                    next_h.cnt = h.cnt + 12'h001;
                    if (h.cnt >= h.hdr) begin
                        next_h.rx = {h.rx[6:0], spi.so_line};
                        next_h.rxn = h.rxn + 3'h1;
                        if (h.rxn == 3'h7) begin
                            next_h.rsp_valid = 1'b1;
                            next_h.rsp_data = {h.rx[6:0], spi.so_line};
                        end
                    end
                end else begin
                    next_h.sclk = 1'b0;
                    if (h.cnt == h.total) begin
                        next_h.state = sfe_pkg::HS_GAP;
                        next_h.gap = sfe_pkg::HOST_GAP;
                    end else begin
                        next_h.sh = {h.sh[38:0], 1'b0};
                        next_h.si = h.sh[38];
                    end
                end
            end
            sfe_pkg::HS_GAP: begin
                next_h.cs_n = 1'b1;
                next_h.gap = h.gap - 2'h1;
                if (h.gap == 2'h0) begin
                    next_h.state = sfe_pkg::HS_IDLE;
                end
            end
            default: begin
                next_h.state = sfe_pkg::HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            h <= '0;
            h.cs_n <= 1'b1;
        end else begin
            h <= next_h;
        end
    end

    assign cmd_ready = h.state == sfe_pkg::HS_IDLE;
    assign rsp_valid = h.rsp_valid;
    assign rsp_data = h.rsp_data;
    assign spi.cs_n = h.cs_n;
    assign spi.sclk = h.sclk;
    assign spi.si = h.si;

endmodule

// ### include/sfe_pkg.sv
// Overview of operation
// - table byte 80h reads E5h
// - table byte 81h reads erase opcode 20h
// - table byte 82h reads F1h fast-read flags
// - bytes 84h-87h give density 007FFFFFh
// - 88h reads 44h, 89h reads EBh
// - 8Ah reads 08h, 8Bh reads 6Bh
// - 8Ch reads 08h, 8Dh reads 3Bh
// - 8Eh reads 80h, 8Fh reads BBh
// - reserved bytes 17h, 18h-7Fh, 90h-FFh read FFh
// - table byte 16h reads 00h
// - three separately erasable 256-byte security registers
// - erase accepted only with write enable latch set
// - host sends 44h then 24-bit address
// - address bits 15:12 pick register 1-3
// - chip select must rise right after bit 32
// - chip select rise starts timed erase
// - busy reads 1 during erase, 0 after
// - erase completion clears write enable latch
// - erase to locked register is ignored
// - table read: 5Ah, address, eight dummies, MSB first
// - table read address bits 23:8 are zero
package sfe_pkg;

    localparam logic [7:0] OP_SFDP = 8'h5a;
    localparam logic [7:0] OP_ERASE = 8'h44;
    localparam logic [7:0] OP_STATUS = 8'h05;
    localparam logic [7:0] OP_WREN = 8'h06;

    // link bit counts, value before the edge that completes a phase
    localparam logic [5:0] OP_LAST_CNT = 6'h07;
    localparam logic [5:0] ADDR_LAST_CNT = 6'h1f;
    localparam logic [5:0] DUMMY_LAST_CNT = 6'h27;
    localparam logic [5:0] LINK_CNT_MAX = 6'h3f;

    // host clocks before read data per command
    localparam logic [11:0] HDR_OP = 12'h008;
    localparam logic [11:0] HDR_ERASE = 12'h020;
    localparam logic [11:0] HDR_SFDP = 12'h028;
    localparam logic [1:0] HOST_GAP = 2'h3;

    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_LATCH_BIT = 1;
    localparam logic [3:0] SECREG_CODE_MAX = 4'h3;
    localparam int SECREG_BYTES = 256;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // value is arbitrary
    localparam logic [7:0] MAKER_ID = 8'h5c;

    localparam int SECTOR_ERASE_TIME_US = 400;
    localparam int CORE_CLK_MHZ = 200;
    localparam int ERASE_CYCLES = SECTOR_ERASE_TIME_US * CORE_CLK_MHZ;

    typedef enum logic [2:0] {
        LM_CMD = 3'b000,
        LM_ADDR = 3'b001,
        LM_DUMMY = 3'b010,
        LM_SFDP = 3'b011,
        LM_STAT = 3'b100,
        LM_IGNORE = 3'b101
    } sfe_lmode_t;

    typedef enum logic [1:0] {
        HK_WREN = 2'b00,
        HK_STATUS = 2'b01,
        HK_SFDP = 2'b10,
        HK_ERASE = 2'b11
    } sfe_hkind_t;

    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_RUN = 2'b01,
        HS_GAP = 2'b10
    } sfe_hstate_t;

    function automatic logic [7:0] sfe_table_byte(input logic [7:0] a);
        case (a)
            8'h00: return 8'h53;
            8'h01: return 8'h46;
            8'h02: return 8'h44;
            8'h03: return 8'h50;
            8'h04, 8'h05, 8'h0a, 8'h12: return 8'h01;
            8'h08, 8'h10: return MAKER_ID;
            8'h0b: return 8'h04;
            8'h0c: return 8'h80;
            8'h14: return 8'h90;
            8'h06, 8'h09, 8'h0d, 8'h0e, 8'h11, 8'h13, 8'h15: return 8'h00;
            8'h16: return 8'h00;
            8'h80: return 8'he5;
            8'h81: return 8'h20;
            8'h82: return 8'hf1;
            8'h86: return 8'h7f;
            8'h87: return 8'h00;
            8'h88: return 8'h44;
            8'h89: return 8'heb;
            8'h8a: return 8'h08;
            8'h8b: return 8'h6b;
            8'h8c: return 8'h08;
            8'h8d: return 8'h3b;
            8'h8e: return 8'h80;
            8'h8f: return 8'hbb;
            default: return 8'hff;
        endcase
    endfunction

endpackage

// ### include/sfe_spi_if.sv
`timescale 1ns/1ps
interface sfe_spi_if;
    logic cs_n;
    logic sclk;
    logic si;
    logic so;
    logic so_oe;
    logic so_line;

    // released line idles high
    assign so_line = so_oe ? so : 1'b1;

    modport device (
        input cs_n,
        input sclk,
        input si,
        output so,
        output so_oe
    );

    modport host (
        output cs_n,
        output sclk,
        output si,
        input so_line
    );
endinterface

// ### testbench/sfdp_table_and_secreg_erase_tb.sv
`timescale 1ns/1ps
module sfdp_table_and_secreg_erase_tb;
    localparam int ERASE_N = 300;
    localparam logic [127:0] PT = 128'he520f1ffffff7f0044eb086b083b80bb;
    localparam logic [23:0] BAD [5] = '{24'h002000, 24'h002000, 24'h004000,
        24'h002100, 24'h012000};
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_ready, rsp_valid, busy, latch_clear;
    sfe_pkg::sfe_hkind_t cmd_kind = sfe_pkg::HK_WREN;
    logic [23:0] cmd_addr = 24'h000000;
    logic [7:0] cmd_len = 8'h00;
    logic [7:0] rsp_data, rd_data;
    logic write_enable_latch = 1'b0;
    logic [2:0] secreg_lock_bits = 3'h0;
    logic prog_we = 1'b0;
    logic [1:0] prog_sel = 2'h0;
    logic [1:0] rd_sel = 2'h0;
    logic [7:0] prog_addr = 8'h00;
    logic [7:0] prog_data = 8'h00;
    logic [7:0] rd_addr = 8'h00;
    logic [7:0] exp_q [$];
    logic [7:0] pat [1:3];
    logic [7:0] pa;
    int errors = 0;
    int n_checks = 0;
    int seed;

    always #2.5 core_clk = ~core_clk;

    sfe_spi_if sfe_spi_if_i ();
    sfe_flash_dev #(.ERASE_CYCLES(ERASE_N)) sfe_flash_dev_i (
        .core_clk(core_clk), .reset(reset), .spi(sfe_spi_if_i),
        .write_enable_latch(write_enable_latch),
        .secreg_lock_bits(secreg_lock_bits), .busy(busy),
        .latch_clear(latch_clear), .prog_we(prog_we), .prog_sel(prog_sel),
        .prog_addr(prog_addr), .prog_data(prog_data), .rd_sel(rd_sel),
        .rd_addr(rd_addr), .rd_data(rd_data));
    sfe_flash_host sfe_flash_host_i (
        .core_clk(core_clk), .reset(reset), .spi(sfe_spi_if_i),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind),
        .cmd_addr(cmd_addr), .cmd_len(cmd_len), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data));
    sfe_spi_sva #(.ERASE_CYCLES(ERASE_N)) sfe_spi_sva_i (
        .core_clk(core_clk), .reset(reset), .cs_n(sfe_spi_if_i.cs_n),
        .sclk(sfe_spi_if_i.sclk), .si(sfe_spi_if_i.si),
        .so_oe(sfe_spi_if_i.so_oe), .busy(busy), .latch_clear(latch_clear),
        .write_enable_latch(write_enable_latch),
        .secreg_lock_bits(secreg_lock_bits));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic cmd(input sfe_pkg::sfe_hkind_t k, input logic [23:0] a,
        input logic [7:0] n);
        int i;
        cmd_kind = k;
        cmd_addr = a;
        cmd_len = n;
        cmd_valid = 1'b1;
        tick(1);
        cmd_valid = 1'b0;
        for (i = 0; i < 2000 && cmd_ready !== 1'b1; i++) tick(1);
        check("cmd_ready", 8'h01, {7'h0, cmd_ready});
        if (cmd_ready !== 1'b1) test_done();
    endtask

    function automatic logic [7:0] tbl(input logic [7:0] a);
        if (a[7:4] == 4'h8) return PT[8 * (15 - a[3:0]) +: 8];
        if (a == 8'h16) return 8'h00;
        return 8'hff;
    endfunction

    task automatic sfdp(input logic [23:0] a, input logic [7:0] n);
        for (int i = 0; i < n; i++) exp_q.push_back(tbl(a[7:0] + 8'(i)));
        cmd(sfe_pkg::HK_SFDP, a, n);
    endtask

    task automatic status(input logic [7:0] e);
        exp_q.push_back(e);
        cmd(sfe_pkg::HK_STATUS, 24'h000000, 8'h01);
    endtask

    task automatic prog(input logic [1:0] s, input logic [7:0] a,
        input logic [7:0] d);
        prog_sel = s;
        prog_addr = a;
        prog_data = d;
        prog_we = 1'b1;
        tick(1);
        prog_we = 1'b0;
    endtask

    task automatic rd(input logic [1:0] s, input logic [7:0] a,
        input logic [7:0] e);
        rd_sel = s;
        rd_addr = a;
        tick(1);
        check("rd_data", e, rd_data);
    endtask

    task automatic wait_busy(input logic v);
        int i;
        for (i = 0; i < 1000 && busy !== v; i++) tick(1);
        check("busy", {7'h0, v}, {7'h0, busy});
        if (busy !== v) test_done();
    endtask

    always @(posedge core_clk) begin
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("rsp_extra", 8'h00, 8'hxx);
            end else begin
                check("rsp_data", exp_q.pop_front(), rsp_data);
            end
        end
        if (latch_clear === 1'b1) begin
            #1 write_enable_latch = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed = $urandom(99325);
        tick(20);
        reset = 1'b0;
        tick(2);
        sfdp(24'h000016, 8'h03);
        sfdp(24'h00007f, 8'h12);
        sfdp(24'h0000ff, 8'h01);
        exp_q.push_back(8'hff);
        cmd(sfe_pkg::HK_SFDP, 24'h000180, 8'h01);
        pa = 8'($urandom_range(255));
        for (int s = 1; s <= 3; s++) begin
            pat[s] = {1'b0, 7'($urandom)};
            prog(2'(s), pa, pat[s]);
            rd(2'(s), pa, pat[s]);
        end
        for (int c = 0; c < 5; c++) begin
            write_enable_latch = (c != 0);
            secreg_lock_bits = (c == 1) ? 3'h2 : 3'h0;
            cmd(sfe_pkg::HK_ERASE, {BAD[c][23:8], 8'($urandom)}, 8'h00);
            tick(10);
            check("busy", 8'h00, {7'h0, busy});
            check("latch", {7'h0, c != 0}, {7'h0, write_enable_latch});
            rd(2'h2, pa, pat[2]);
        end
        secreg_lock_bits = 3'h1;
        cmd(sfe_pkg::HK_WREN, 24'h000000, 8'h00);
        write_enable_latch = 1'b1;
        cmd(sfe_pkg::HK_ERASE, {16'h0020, 8'($urandom)}, 8'h00);
        wait_busy(1'b1);
        status(8'h03);
        cmd(sfe_pkg::HK_ERASE, 24'h003000, 8'h00);
        exp_q.push_back(8'hff);
        cmd(sfe_pkg::HK_SFDP, 24'h000080, 8'h01);
        wait_busy(1'b0);
        tick(4);
        check("latch", 8'h00, {7'h0, write_enable_latch});
        status(8'h00);
        rd(2'h2, pa, 8'hff);
        rd(2'h2, 8'h00, 8'hff);
        rd(2'h2, 8'hff, 8'hff);
        rd(2'h1, pa, pat[1]);
        rd(2'h3, pa, pat[3]);
        tick(4);
        check("pending", 8'h00, 8'(exp_q.size()));
        test_done();
    end
endmodule

// ### testbench/sfe_spi_sva.sv
`timescale 1ns/1ps
module sfe_spi_sva #(
    parameter int ERASE_CYCLES = 300
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic si,
    input wire logic so_oe,
    input wire logic busy,
    input wire logic latch_clear,
    input wire logic write_enable_latch,
    input wire logic [2:0] secreg_lock_bits
);
    // ------------------------------------------------------------
    // frame tracking in the core domain
    // ------------------------------------------------------------
    logic sclk_q, cs_q, rise, frame_end, code_ok, erase_op, erase_ok;
    logic [5:0] cnt;
    logic [31:0] sh, fr_q, bcnt;
    logic [7:0] op_q;
    logic [3:0] code;

    assign rise = sclk && !sclk_q && !cs_n;
    assign frame_end = cs_n && !cs_q;
    assign code = fr_q[15:12];
    assign code_ok = code >= 4'h1 && code <= 4'h3;
    assign erase_op = frame_end && op_q == sfe_pkg::OP_ERASE && cnt >= 6'h20;
    assign erase_ok = erase_op && cnt == 6'h20 && fr_q[23:16] == 8'h00
        && fr_q[11:8] == 4'h0 && code_ok && write_enable_latch
        && !secreg_lock_bits[code[1:0] - 2'h1] && !busy;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            sclk_q <= 1'b0;
            cs_q <= 1'b1;
            cnt <= 6'h00;
            sh <= 32'h0;
            fr_q <= 32'h0;
            op_q <= 8'h00;
            bcnt <= 32'h0;
        end else begin
            sclk_q <= sclk;
            cs_q <= cs_n;
            bcnt <= busy ? bcnt + 32'h1 : 32'h0;
            if (cs_n) begin
                cnt <= 6'h00;
            end else if (rise) begin
                if (cnt != 6'h3f) begin
                    cnt <= cnt + 6'h01;
                end
                sh <= {sh[30:0], si};
                if (cnt == 6'h07) begin
                    op_q <= {sh[6:0], si};
                end
                if (cnt == 6'h1f) begin
                    fr_q <= {sh[30:0], si};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    property p_oe_idle;
        cs_n && $past(cs_n) |-> !so_oe;
    endproperty
    a_oe_idle: assert property (p_oe_idle)
        else $error("so_oe high outside a frame");

    property p_busy_start;
        erase_ok |-> ##[1:8] busy;
    endproperty
    a_busy_start: assert property (p_busy_start)
        else $error("accepted erase did not raise busy");

    property p_refuse;
        erase_op && !busy && !erase_ok |-> !busy [*8];
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("refused erase raised busy");

    property p_busy_len;
        $fell(busy) |-> bcnt >= ERASE_CYCLES - 1 && bcnt <= ERASE_CYCLES + 1;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy length wrong");

    property p_latch_after;
        $fell(busy) |-> ##[0:2] latch_clear;
    endproperty
    a_latch_after: assert property (p_latch_after)
        else $error("no latch clear at erase end");

    property p_latch_pulse;
        latch_clear |=> !latch_clear && !busy;
    endproperty
    a_latch_pulse: assert property (p_latch_pulse)
        else $error("latch clear not a single pulse");

    property p_busy_status;
        so_oe && busy |-> op_q == sfe_pkg::OP_STATUS;
    endproperty
    a_busy_status: assert property (p_busy_status)
        else $error("output driven for non-status command while busy");

    property p_sfdp_addr;
        so_oe && op_q == sfe_pkg::OP_SFDP |-> fr_q[23:8] == 16'h0000;
    endproperty
    a_sfdp_addr: assert property (p_sfdp_addr)
        else $error("table output for bad address");
endmodule
